// ==== rtl/sd_tt_cfg.svh ====
`ifndef SD_TT_CFG_SVH
`define SD_TT_CFG_SVH

// ********************************************************************
// Register word addresses
// ********************************************************************
`define REG_ADDR_W          5
`define REG_CFG_ONE         5'h00
`define REG_CFG_TWO         5'h01
`define REG_TIMETAG         5'h08
`define REG_BIT_WORD        5'h14
`define REG_IRQ_STATUS      5'h1a
`define REG_IRQ_MASK        5'h1b

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define CFG1_SD_MODE_BIT    12
`define CFG1_TT_SRC_LSB     9
`define CFG1_TT_SRC_MSB     11
`define CFG2_MC_OPTION_BIT  4
`define CFG1_RESET          16'h0000
`define CFG2_RESET          16'h0000
`define BIT_A_TX_OFF        0
`define BIT_A_RX_OFF        1
`define BIT_B_TX_OFF        2
`define BIT_B_RX_OFF        3
`define IRQ_SHUTDOWN        0
`define IRQ_OVERRIDE        1
`define IRQ_TT_WRAP         2
`define IRQ_W               3
`define IRQ_RESET           3'h0

// ********************************************************************
// Time-tag clock selection codes
// ********************************************************************
`define TT_SEL_OFF          3'h0
`define TT_SEL_EXT          3'h1
`define TT_SEL_2US          3'h2
`define TT_SEL_4US          3'h3
`define TT_SEL_8US          3'h4
`define TT_SEL_16US         3'h5
`define TT_SEL_32US         3'h6
`define TT_SEL_64US         3'h7

// ********************************************************************
// Timing: periods in ns, cycle counts derived from the clock rate
// ********************************************************************
`define CLK_PERIOD_NS       25
`define TT_2US_NS           2000
`define TT_4US_NS           4000
`define TT_8US_NS           8000
`define TT_16US_NS          16000
`define TT_32US_NS          32000
`define TT_64US_NS          64000
`define TT_2US_CYC          (`TT_2US_NS / `CLK_PERIOD_NS)
`define TT_4US_CYC          (`TT_4US_NS / `CLK_PERIOD_NS)
`define TT_8US_CYC          (`TT_8US_NS / `CLK_PERIOD_NS)
`define TT_16US_CYC         (`TT_16US_NS / `CLK_PERIOD_NS)
`define TT_32US_CYC         (`TT_32US_NS / `CLK_PERIOD_NS)
`define TT_64US_CYC         (`TT_64US_NS / `CLK_PERIOD_NS)
`define TT_DIV_W            12

`endif

// ==== rtl/sd_tt_pkg.sv ====
package sd_tt_pkg;
  // Shutdown state of one bus
  typedef enum logic [1:0] {
    BUS_ON,
    BUS_MUTED,
    BUS_OFF
  } bus_state_t;
endpackage

// ==== rtl/timetag_if.sv ====
`timescale 1ns/1ps
// Links the configuration logic, tick generator and time-tag counter
interface timetag_if;
  logic [2:0]  sel;
  logic        ext_clk;
  logic        tick;
  logic [15:0] count;
  logic        wrap;
  modport gen (input sel, input ext_clk, output tick);
  modport cnt (input sel, input tick, output count, output wrap);
  modport ctl (output sel, output ext_clk, input count, input wrap);
endinterface

// ==== rtl/timetag_tick_gen.sv ====
`timescale 1ns/1ps
`include "sd_tt_cfg.svh"
module timetag_tick_gen
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  timetag_if.gen    tt
);
  import sd_tt_pkg::*;

  logic [`TT_DIV_W-1:0] div_r;
  logic [`TT_DIV_W-1:0] period_m1;
  logic [2:0]           sel_r;
  logic                 ext_r;
  logic                 tick_r;

  // Internal period for each select code, less one
  always_comb
  begin
    case (tt.sel)
      `TT_SEL_2US:  period_m1 = `TT_DIV_W'(`TT_2US_CYC - 1);
      `TT_SEL_4US:  period_m1 = `TT_DIV_W'(`TT_4US_CYC - 1);
      `TT_SEL_8US:  period_m1 = `TT_DIV_W'(`TT_8US_CYC - 1);
      `TT_SEL_16US: period_m1 = `TT_DIV_W'(`TT_16US_CYC - 1);
      `TT_SEL_32US: period_m1 = `TT_DIV_W'(`TT_32US_CYC - 1);
      `TT_SEL_64US: period_m1 = `TT_DIV_W'(`TT_64US_CYC - 1);
      default:      period_m1 = '0;
    endcase
  end

  // Remember selection and pin level for restart and edge detection
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sel_r <= `TT_SEL_OFF;
      ext_r <= 1'b0;
    end
    else
    begin
      sel_r <= tt.sel;
      ext_r <= tt.ext_clk;
    end
  end

  // Divider restarts whenever the selection changes
  always_ff @(posedge clk_in)
  begin
    if (rst_in || tt.sel != sel_r || tt.sel < `TT_SEL_2US)
      div_r <= '0;
    else if (div_r == period_m1)
      div_r <= '0;
    else
      div_r <= div_r + `TT_DIV_W'(1);
  end

  // One tick per period, per pin rising edge, none when disabled
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tick_r <= 1'b0;
    else if (tt.sel == `TT_SEL_EXT)
      tick_r <= tt.ext_clk & ~ext_r;
    else if (tt.sel >= `TT_SEL_2US && tt.sel == sel_r)
      tick_r <= (div_r == period_m1);
    else
      tick_r <= 1'b0;
  end

  assign tt.tick = tick_r;

  a_ext_edge_tick : assert property (@(posedge clk_in) disable iff (rst_in)
    (tt.sel == `TT_SEL_EXT && tt.ext_clk && !ext_r) |=> tick_r)
    else $error("external pin edge gave no tick");

  a_two_us_gap : assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_r && tt.sel == `TT_SEL_2US && sel_r == `TT_SEL_2US)
      ##1 (tt.sel == `TT_SEL_2US) [*8] |-> !tick_r)
    else $error("2 us tick period too short");
endmodule

// ==== rtl/timetag_counter.sv ====
`timescale 1ns/1ps
`include "sd_tt_cfg.svh"
module timetag_counter
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  timetag_if.cnt    tt
);
  import sd_tt_pkg::*;

  logic [15:0] count_r;
  logic        wrap_r;

  // Advance on each tick, hold while disabled
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_r <= 16'h0000;
      wrap_r  <= 1'b0;
    end
    else
    begin
      wrap_r <= 1'b0;
      if (tt.tick && tt.sel != `TT_SEL_OFF)
      begin
        count_r <= count_r + 16'h0001;
        wrap_r  <= (count_r == 16'hffff);
      end
    end
  end

  assign tt.count = count_r;
  assign tt.wrap  = wrap_r;

  a_hold_disabled : assert property (@(posedge clk_in) disable iff (rst_in)
    (tt.sel == `TT_SEL_OFF) |=> (count_r == $past(count_r)))
    else $error("time-tag moved while disabled");

  a_tick_advance : assert property (@(posedge clk_in) disable iff (rst_in)
    (tt.tick && tt.sel != `TT_SEL_OFF) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("time-tag missed a tick");
endmodule

// ==== rtl/shutdown_timetag_ctrl.sv ====
// Contract
// - Shutdown select acts only when option clear
// - Both zero: shutdown kills inactive tx and rx
// - Reset clears shutdown select and option bit
// - Select one: inactive transmitter off, receiver kept
// - Muted bus still receives, never transmits
// - Test word shows shutdown state when option clear
// - Code 000 disables, 001 uses pin
// - Codes 010..100 give 2, 4, 8 us
// - Codes 101..111 give 16, 32, 64 us
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "sd_tt_cfg.svh"
module shutdown_timetag_ctrl
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [`REG_ADDR_W-1:0]  addr_in,
  input  wire logic [15:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [15:0]             rdata_out,
  input  wire logic                    shutdown_cmd_in,
  input  wire logic                    sel_shutdown_cmd_in,
  input  wire logic                    override_cmd_in,
  input  wire logic                    bus_b_active_in,
  input  wire logic                    external_timetag_clock_pin_in,
  output logic                         bus_a_tx_en_out,
  output logic                         bus_a_rx_en_out,
  output logic                         bus_b_tx_en_out,
  output logic                         bus_b_rx_en_out,
  output sd_tt_pkg::bus_state_t        bus_a_state_out,
  output sd_tt_pkg::bus_state_t        bus_b_state_out,
  output logic      [15:0]             timetag_out,
  output logic                         irq_out
);
  import sd_tt_pkg::*;

  // ******************************************************************
  // Storage
  // ******************************************************************
  logic [15:0]          terminal_config_one_r;
  logic [15:0]          terminal_config_two_r;
  logic [`IRQ_W-1:0]    irq_status_r;
  logic [`IRQ_W-1:0]    irq_mask_r;
  logic [`IRQ_W-1:0]    irq_event;
  bus_state_t           state_a_r;
  bus_state_t           state_b_r;
  bus_state_t           state_a_nxt;
  bus_state_t           state_b_nxt;
  bus_state_t           shut_state;
  logic                 shutdown_mode_select;
  logic                 mode_code_handling_option;
  logic [2:0]           timetag_clock_source_field;
  logic                 auto_shutdown_en;
  logic                 any_shutdown;
  logic [15:0]          bit_word;
  logic [15:0]          rdata_nxt;
  logic [15:0]          timetag_r;

  timetag_if tt ();

  // ******************************************************************
  // Field decode
  // ******************************************************************

  // Named views of the configuration fields
  assign shutdown_mode_select       = terminal_config_one_r[`CFG1_SD_MODE_BIT];
  assign mode_code_handling_option  = terminal_config_two_r[`CFG2_MC_OPTION_BIT];
  assign timetag_clock_source_field =
    terminal_config_one_r[`CFG1_TT_SRC_MSB:`CFG1_TT_SRC_LSB];

  // Automatic shutdown only when the option bit is clear
  assign auto_shutdown_en = ~mode_code_handling_option;
  assign any_shutdown     = shutdown_cmd_in | sel_shutdown_cmd_in;

  // Resulting state of a bus that is shut down
  assign shut_state = shutdown_mode_select ? BUS_MUTED : BUS_OFF;

  // ******************************************************************
  // Register writes
  // ******************************************************************

  // First configuration register, cleared by master reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      terminal_config_one_r <= `CFG1_RESET;
    else if (wr_in && addr_in == `REG_CFG_ONE)
      terminal_config_one_r <= wdata_in;
  end

  // Second configuration register, holds the option bit
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      terminal_config_two_r <= `CFG2_RESET;
    else if (wr_in && addr_in == `REG_CFG_TWO)
      terminal_config_two_r <= wdata_in;
  end

  // Interrupt mask
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_mask_r <= `IRQ_RESET;
    else if (wr_in && addr_in == `REG_IRQ_MASK)
      irq_mask_r <= wdata_in[`IRQ_W-1:0];
  end

  // ******************************************************************
  // Bus shutdown state
  // ******************************************************************

  // Next state of both buses; the inactive bus is the one shut down
  always_comb
  begin
    state_a_nxt = state_a_r;
    state_b_nxt = state_b_r;
    if (override_cmd_in)
    begin
      state_a_nxt = BUS_ON;
      state_b_nxt = BUS_ON;
    end
    else if (any_shutdown && auto_shutdown_en)
    begin
      if (bus_b_active_in)
        state_a_nxt = shut_state;
      else
        state_b_nxt = shut_state;
    end
  end

  // Shutdown state flip-flops
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_a_r <= BUS_ON;
      state_b_r <= BUS_ON;
    end
    else
    begin
      state_a_r <= state_a_nxt;
      state_b_r <= state_b_nxt;
    end
  end

  // Transmitter and receiver enables; muted bus keeps its receiver
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bus_a_tx_en_out <= 1'b1;
      bus_a_rx_en_out <= 1'b1;
      bus_b_tx_en_out <= 1'b1;
      bus_b_rx_en_out <= 1'b1;
    end
    else
    begin
      case (state_a_nxt)
        BUS_ON:
        begin
          bus_a_tx_en_out <= 1'b1;
          bus_a_rx_en_out <= 1'b1;
        end
        BUS_MUTED:
        begin
          bus_a_tx_en_out <= 1'b0;
          bus_a_rx_en_out <= 1'b1;
        end
        default:
        begin
          bus_a_tx_en_out <= 1'b0;
          bus_a_rx_en_out <= 1'b0;
        end
      endcase
      case (state_b_nxt)
        BUS_ON:
        begin
          bus_b_tx_en_out <= 1'b1;
          bus_b_rx_en_out <= 1'b1;
        end
        BUS_MUTED:
        begin
          bus_b_tx_en_out <= 1'b0;
          bus_b_rx_en_out <= 1'b1;
        end
        default:
        begin
          bus_b_tx_en_out <= 1'b0;
          bus_b_rx_en_out <= 1'b0;
        end
      endcase
    end
  end

  // State outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bus_a_state_out <= BUS_ON;
      bus_b_state_out <= BUS_ON;
    end
    else
    begin
      bus_a_state_out <= state_a_nxt;
      bus_b_state_out <= state_b_nxt;
    end
  end

  // Test word flags, hidden while the option bit is set
  always_comb
  begin
    bit_word = 16'h0000;
    if (auto_shutdown_en)
    begin
      bit_word[`BIT_A_TX_OFF] = (state_a_r != BUS_ON);
      bit_word[`BIT_A_RX_OFF] = (state_a_r == BUS_OFF);
      bit_word[`BIT_B_TX_OFF] = (state_b_r != BUS_ON);
      bit_word[`BIT_B_RX_OFF] = (state_b_r == BUS_OFF);
    end
  end

  // ******************************************************************
  // Time-tag
  // ******************************************************************

  // Selection and pin into the tick generator
  assign tt.sel     = timetag_clock_source_field;
  assign tt.ext_clk = external_timetag_clock_pin_in;

  timetag_tick_gen u_tick
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tt     (tt.gen)
  );

  timetag_counter u_count
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tt     (tt.cnt)
  );

  // Registered copy of the count for the output port
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      timetag_r <= 16'h0000;
    else
      timetag_r <= tt.count;
  end

  assign timetag_out = timetag_r;

  // ******************************************************************
  // Interrupts
  // ******************************************************************

  // Events: shutdown applied, override, counter wrap
  always_comb
  begin
    irq_event                = '0;
    irq_event[`IRQ_SHUTDOWN] = any_shutdown & auto_shutdown_en & ~override_cmd_in;
    irq_event[`IRQ_OVERRIDE] = override_cmd_in;
    irq_event[`IRQ_TT_WRAP]  = tt.wrap;
  end

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_status_r <= `IRQ_RESET;
    else if (wr_in && addr_in == `REG_IRQ_STATUS)
      irq_status_r <= (irq_status_r & ~wdata_in[`IRQ_W-1:0]) | irq_event;
    else
      irq_status_r <= irq_status_r | irq_event;
  end

  // Level interrupt while any unmasked bit is set
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status_r & irq_mask_r);
  end

  // ******************************************************************
  // Register reads
  // ******************************************************************

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    if (addr_in == `REG_CFG_ONE)
      rdata_nxt = terminal_config_one_r;
    else if (addr_in == `REG_CFG_TWO)
      rdata_nxt = terminal_config_two_r;
    else if (addr_in == `REG_TIMETAG)
      rdata_nxt = tt.count;
    else if (addr_in == `REG_BIT_WORD)
      rdata_nxt = bit_word;
    else if (addr_in == `REG_IRQ_STATUS)
      rdata_nxt = {{(16-`IRQ_W){1'b0}}, irq_status_r};
    else if (addr_in == `REG_IRQ_MASK)
      rdata_nxt = {{(16-`IRQ_W){1'b0}}, irq_mask_r};
    else
      rdata_nxt = 16'h0000;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
      rdata_out <= rdata_nxt;
    else
      rdata_out <= 16'h0000;
  end

  // ******************************************************************
  // Checks
  // ******************************************************************

  a_full_shutdown_b : assert property (@(posedge clk_in) disable iff (rst_in)
    (shutdown_cmd_in && !override_cmd_in && !bus_b_active_in
      && !mode_code_handling_option && !shutdown_mode_select)
      |=> (!bus_b_tx_en_out && !bus_b_rx_en_out))
    else $error("bus B not fully shut down");

  a_muted_keeps_rx : assert property (@(posedge clk_in) disable iff (rst_in)
    (any_shutdown && !override_cmd_in && bus_b_active_in
      && !mode_code_handling_option && shutdown_mode_select)
      |=> (!bus_a_tx_en_out && bus_a_rx_en_out && bus_a_state_out == BUS_MUTED))
    else $error("bus A not muted");

  a_option_blocks : assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_code_handling_option && !override_cmd_in)
      |=> (bus_a_tx_en_out == $past(bus_a_tx_en_out)
           && bus_b_rx_en_out == $past(bus_b_rx_en_out)))
    else $error("shutdown acted with option set");

  a_reset_defaults : assert property (@(posedge clk_in)
    rst_in |=> (!shutdown_mode_select && !mode_code_handling_option
                && bus_a_tx_en_out && bus_b_rx_en_out))
    else $error("reset defaults wrong");

  a_muted_no_tx : assert property (@(posedge clk_in) disable iff (rst_in)
    (bus_b_state_out == BUS_MUTED) |-> (!bus_b_tx_en_out && bus_b_rx_en_out))
    else $error("muted bus may transmit");

  a_bit_hidden : assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == `REG_BIT_WORD && mode_code_handling_option)
      |=> (rdata_out == 16'h0000))
    else $error("test word flags shown with option set");

  a_bit_shows_off : assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == `REG_BIT_WORD && !mode_code_handling_option
      && state_b_r == BUS_OFF) |=> (rdata_out[`BIT_B_RX_OFF] && rdata_out[`BIT_B_TX_OFF]))
    else $error("test word misses bus B shutdown");

  a_tt_disabled : assert property (@(posedge clk_in) disable iff (rst_in)
    (timetag_clock_source_field == `TT_SEL_OFF) [*3] |-> !tt.tick)
    else $error("tick while time-tag disabled");

  a_irq_level : assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 (irq_out == |($past(irq_status_r) & $past(irq_mask_r))))
    else $error("interrupt level wrong");
endmodule

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`include "sd_tt_cfg.svh"
// ********************************************************************
// Host processor model on the register port
// ********************************************************************
module host_model
(
  input  wire logic                   clk_in,
  input  wire logic [15:0]            rdata_in,
  output logic      [`REG_ADDR_W-1:0] addr_out,
  output logic      [15:0]            wdata_out,
  output logic                        wr_out,
  output logic                        rd_out
);
  // Idle bus from time zero
  initial
  begin
    addr_out  = '0;
    wdata_out = '0;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic write_reg(input logic [`REG_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic read_reg(input logic [`REG_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

// ==== dv/shutdown_and_timetag_clock_select_tb.sv ====
`timescale 1ns/1ps
`include "sd_tt_cfg.svh"
module shutdown_and_timetag_clock_select_tb;
  import sd_tt_pkg::*;
  logic                   clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic [`REG_ADDR_W-1:0] addr;
  logic [15:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [15:0]            rdata;
  logic                   sd_cmd = 1'b0;
  logic                   ssd_cmd = 1'b0;
  logic                   ovr_cmd = 1'b0;
  logic                   b_active = 1'b0;
  logic                   tt_pin = 1'b0;
  logic                   a_tx, a_rx, b_tx, b_rx, irq;
  bus_state_t             st_a, st_b;
  logic [15:0]            tt_val, d, c0, c1;
  int                     fails = 0;
  int                     cmp_count = 0;
  int                     p;
  wire  [15:0]            ens = {12'h000, a_tx, a_rx, b_tx, b_rx};

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  host_model host_model_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  shutdown_timetag_ctrl shutdown_timetag_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .shutdown_cmd_in(sd_cmd), .sel_shutdown_cmd_in(ssd_cmd), .override_cmd_in(ovr_cmd),
    .bus_b_active_in(b_active), .external_timetag_clock_pin_in(tt_pin),
    .bus_a_tx_en_out(a_tx), .bus_a_rx_en_out(a_rx), .bus_b_tx_en_out(b_tx),
    .bus_b_rx_en_out(b_rx), .bus_a_state_out(st_a), .bus_b_state_out(st_b),
    .timetag_out(tt_val), .irq_out(irq));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let registered outputs land
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // One-cycle mode command pulse: 0 shutdown, 1 selected shutdown, 2 override
  task automatic pulse_cmd(input int k);
    @(posedge clk_in);
    sd_cmd  <= (k == 0);
    ssd_cmd <= (k == 1);
    ovr_cmd <= (k == 2);
    @(posedge clk_in);
    {sd_cmd, ssd_cmd, ovr_cmd} <= 3'h0;
    settle();
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 23000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_in);
    fails = fails + 1;
    summarize();
  end

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    host_model_i.read_reg(`REG_CFG_ONE, d); chk(d, 16'h0000);
    host_model_i.read_reg(`REG_CFG_TWO, d); chk(d, 16'h0000);
    chk(ens, 16'h000f);
    // Complete shutdown of inactive bus B, the preferred setting
    host_model_i.write_reg(`REG_CFG_ONE, 16'h0000);
    pulse_cmd(0);
    chk(ens, 16'h000c);
    chk({14'h0, st_b}, {14'h0, BUS_OFF});
    host_model_i.read_reg(`REG_BIT_WORD, d); chk(d, 16'h000c);
    // Interrupt: masked, unmasked, then cleared by writing one
    chk({15'h0, irq}, 16'h0000);
    host_model_i.write_reg(`REG_IRQ_MASK, 16'h0001);
    settle();
    chk({15'h0, irq}, 16'h0001);
    host_model_i.write_reg(`REG_IRQ_STATUS, 16'h0001);
    settle();
    chk({15'h0, irq}, 16'h0000);
    // Mute inactive bus A: transmitter off, receiver kept
    pulse_cmd(2);
    @(posedge clk_in);
    b_active <= 1'b1;
    host_model_i.write_reg(`REG_CFG_ONE, 16'h1000);
    pulse_cmd(1);
    chk(ens, 16'h0007);
    chk({14'h0, st_a}, {14'h0, BUS_MUTED});
    host_model_i.read_reg(`REG_BIT_WORD, d); chk(d, 16'h0001);
    // Option bit set: flags hidden, the shutdown command (pulse 0) has no effect
    host_model_i.write_reg(`REG_CFG_TWO, 16'h0010);
    host_model_i.read_reg(`REG_BIT_WORD, d); chk(d, 16'h0000);
    pulse_cmd(2);
    host_model_i.write_reg(`REG_IRQ_STATUS, 16'h0007);
    host_model_i.write_reg(`REG_CFG_ONE, 16'h0000);
    pulse_cmd(0);
    chk(ens, 16'h000f);
    host_model_i.read_reg(`REG_IRQ_STATUS, d); chk(d & 16'h0001, 16'h0000);
    host_model_i.read_reg(`REG_BIT_WORD, d); chk(d, 16'h0000);
    // Field 000 holds the count
    host_model_i.read_reg(`REG_TIMETAG, c0);
    repeat (200) @(posedge clk_in);
    host_model_i.read_reg(`REG_TIMETAG, c1); chk(c1, c0);
    // Field 001: five rising edges on the external pin
    host_model_i.write_reg(`REG_CFG_ONE, 16'h0200);
    host_model_i.read_reg(`REG_TIMETAG, c0);
    repeat (5)
    begin
      @(posedge clk_in);
      tt_pin <= 1'b1;
      @(posedge clk_in);
      tt_pin <= 1'b0;
    end
    settle();
    host_model_i.read_reg(`REG_TIMETAG, c1); chk(c1, c0 + 16'h0005);
    chk(tt_val, c1);
    // Internal periods: four ticks within four and a half periods
    for (int code = 2; code < 8; code++)
    begin
      p = 80 << (code - 2);
      host_model_i.write_reg(`REG_CFG_ONE, 16'(code) << `CFG1_TT_SRC_LSB);
      host_model_i.read_reg(`REG_TIMETAG, c0);
      repeat (4 * p + p / 2) @(posedge clk_in);
      host_model_i.read_reg(`REG_TIMETAG, c1); chk(c1, c0 + 16'h0004);
      chk(tt_val, c1);
    end
    summarize();
  end
endmodule
